// ### rtl/mbsm_pkg.sv
// shared constants and carrier types for the modem slave request interpreter
package mbsm_pkg;

  // supported function codes
  localparam logic [7:0] FC_RD_COILS  = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD   = 8'h03;
  localparam logic [7:0] FC_RD_AIN    = 8'h04;
  localparam logic [7:0] FC_WR_COIL   = 8'h05;
  localparam logic [7:0] FC_WR_REG    = 8'h06;
  localparam logic [7:0] FC_WR_COILS  = 8'h0f;
  localparam logic [7:0] FC_WR_REGS   = 8'h10;

  // exception codes answered to the master
  localparam logic [7:0] EXC_NONE     = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS  = 8'h02;
  localparam logic [7:0] EXC_VALUE    = 8'h03;

  // mapped range sizes and request limits
  localparam logic [16:0] BIT_ITEMS    = 17'h00080;  // 128 coils / 128 inputs
  localparam logic [16:0] AIN_ITEMS    = 17'h00020;  // 32 analog input words
  localparam logic [16:0] VAR_ITEMS    = 17'h08000;  // byte offset must fit 16 bits
  localparam logic [15:0] MAX_REGS     = 16'h007d;   // 125 registers, 250 bytes
  localparam logic [15:0] COIL_ON      = 16'hff00;
  localparam logic [15:0] COIL_OFF     = 16'h0000;

  // host memory areas on the expansion bus
  localparam logic [1:0] AREA_OUT_IMAGE = 2'h0;
  localparam logic [1:0] AREA_DISC_IN   = 2'h1;
  localparam logic [1:0] AREA_ANALOG_IN = 2'h2;
  localparam logic [1:0] AREA_VARIABLE  = 2'h3;

  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ISSUE, S_WAIT} mbsm_state_t;

  // parsed request from the link framer
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] wdata;
  } mbsm_req_t;

  // one access to host memory over the expansion bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  area;
    logic [15:0] index;
    logic [15:0] wdata;
  } mbsm_cmd_t;

  // response items back to the link framer
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [7:0]  func;
    logic [7:0]  code;
    logic [15:0] data;
  } mbsm_rsp_t;

  typedef struct packed {
    mbsm_state_t st;
    logic        req_ready;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] wdata;
    logic [15:0] cnt;
    logic [1:0]  area;
    logic        item_take;
    logic        pt_refuse;
    mbsm_cmd_t   cmd;
    mbsm_rsp_t   rsp;
  } mbsm_regs_t;

endpackage : mbsm_pkg

// ### rtl/mbsm_top.sv
// request interpreter of the modem slave: decode, map, move data, answer
// Contract
// - serve each link request in slave mode with configuration loaded and send response
// - read functions 01, 02, 03, 04
// - write functions 05, 06, 15, 16
// - at most 125 registers per request
// - coil writes land in output image
// - coils and inputs map to bits 0.0-15.7
// - analog words step two, holding word 2*n
// - refuse programming protocol while in slave mode
// - no service before configuration is loaded
// - all host traffic over expansion bus
`timescale 1ns/1ps
module mbsm_top (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               modbus_mode,
  input  wire logic               cfg_loaded,
  input  wire logic               pt_req,
  output      logic               pt_refuse,
  input  wire mbsm_pkg::mbsm_req_t mb_req,
  output      logic               req_ready,
  input  wire logic [15:0]        item_wdata,
  output      logic               item_take,
  output      mbsm_pkg::mbsm_cmd_t iob_cmd,
  input  wire logic               iob_ack,
  input  wire logic [15:0]        iob_rdata,
  output      mbsm_pkg::mbsm_rsp_t mb_rsp
);

  logic                 rst_meta_q;
  logic                 rst_sync_q;
  mbsm_pkg::mbsm_regs_t q;
  mbsm_pkg::mbsm_regs_t d;
  logic [7:0]           chk_exc;
  logic [16:0]          cur_item;

  // checks function, range and count before any bus traffic
  function automatic logic [7:0] f_exc(input logic [7:0] fc, input logic [15:0] a,
                                       input logic [15:0] n, input logic [15:0] wd);
    logic [16:0] top;
    top = {1'b0, a} + {1'b0, n};
    f_exc = mbsm_pkg::EXC_NONE;
    case (fc)
      mbsm_pkg::FC_RD_COILS, mbsm_pkg::FC_RD_INPUTS, mbsm_pkg::FC_WR_COILS:
        if (n == 16'h0000) f_exc = mbsm_pkg::EXC_VALUE;
        else if (top > mbsm_pkg::BIT_ITEMS) f_exc = mbsm_pkg::EXC_ADDRESS;
      mbsm_pkg::FC_RD_HOLD, mbsm_pkg::FC_WR_REGS:
        if (n == 16'h0000 || n > mbsm_pkg::MAX_REGS) f_exc = mbsm_pkg::EXC_VALUE;
        else if (top > mbsm_pkg::VAR_ITEMS) f_exc = mbsm_pkg::EXC_ADDRESS;
      mbsm_pkg::FC_RD_AIN:
        if (n == 16'h0000 || n > mbsm_pkg::MAX_REGS) f_exc = mbsm_pkg::EXC_VALUE;
        else if (top > mbsm_pkg::AIN_ITEMS) f_exc = mbsm_pkg::EXC_ADDRESS;
      mbsm_pkg::FC_WR_COIL:
        if (wd != mbsm_pkg::COIL_ON && wd != mbsm_pkg::COIL_OFF) f_exc = mbsm_pkg::EXC_VALUE;
        else if (top > mbsm_pkg::BIT_ITEMS) f_exc = mbsm_pkg::EXC_ADDRESS;
      mbsm_pkg::FC_WR_REG:
        if (top > mbsm_pkg::VAR_ITEMS) f_exc = mbsm_pkg::EXC_ADDRESS;
      default:
        f_exc = mbsm_pkg::EXC_FUNCTION;
    endcase
  endfunction : f_exc

  // host memory area for a function code
  function automatic logic [1:0] f_area(input logic [7:0] fc);
    case (fc)
      mbsm_pkg::FC_RD_COILS, mbsm_pkg::FC_WR_COIL, mbsm_pkg::FC_WR_COILS: f_area = mbsm_pkg::AREA_OUT_IMAGE;
      mbsm_pkg::FC_RD_INPUTS: f_area = mbsm_pkg::AREA_DISC_IN;
      mbsm_pkg::FC_RD_AIN:    f_area = mbsm_pkg::AREA_ANALOG_IN;
      default:                f_area = mbsm_pkg::AREA_VARIABLE;
    endcase
  endfunction : f_area

  // write functions, single or multiple
  function automatic logic f_is_write(input logic [7:0] fc);
    f_is_write = (fc == mbsm_pkg::FC_WR_COIL) || (fc == mbsm_pkg::FC_WR_REG) ||
                 (fc == mbsm_pkg::FC_WR_COILS) || (fc == mbsm_pkg::FC_WR_REGS);
  endfunction : f_is_write

  // reset released through two flops, asserted at once
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign chk_exc  = f_exc(q.func, q.addr, q.qty, q.wdata);
  assign cur_item = {1'b0, q.addr} + {1'b0, q.cnt};

  // next state of the interpreter
  always_comb
  begin
    d               = q;
    d.rsp.valid     = 1'b0;
    d.rsp.last      = 1'b0;
    d.item_take     = 1'b0;
    d.pt_refuse     = pt_req & modbus_mode;
    case (q.st)
      mbsm_pkg::S_IDLE:
      begin
        d.req_ready = 1'b1;
        // requests without slave mode or configuration are dropped unanswered
        if (mb_req.valid && q.req_ready && modbus_mode && cfg_loaded)
        begin
          d.req_ready = 1'b0;
          d.func      = mb_req.func;
          d.addr      = mb_req.addr;
          d.wdata     = mb_req.wdata;
          d.qty       = (mb_req.func == mbsm_pkg::FC_WR_COIL || mb_req.func == mbsm_pkg::FC_WR_REG) ?
                        16'h0001 : mb_req.qty;
          d.st        = mbsm_pkg::S_CHECK;
        end
      end
      mbsm_pkg::S_CHECK:
      begin
        d.cnt  = 16'h0000;
        d.area = f_area(q.func);
        if (chk_exc != mbsm_pkg::EXC_NONE)
        begin
          // refused before any host access
          d.rsp.valid = 1'b1;
          d.rsp.last  = 1'b1;
          d.rsp.func  = q.func;
          d.rsp.code  = chk_exc;
          d.rsp.data  = 16'h0000;
          d.req_ready = 1'b1;
          d.st        = mbsm_pkg::S_IDLE;
        end
        else
        begin
          d.st = mbsm_pkg::S_ISSUE;
        end
      end
      mbsm_pkg::S_ISSUE:
      begin
        d.cmd.valid = 1'b1;
        d.cmd.write = f_is_write(q.func);
        d.cmd.area  = q.area;
        // bits address by bit number, words by byte offset 2*n
        if (q.area == mbsm_pkg::AREA_OUT_IMAGE || q.area == mbsm_pkg::AREA_DISC_IN)
          d.cmd.index = cur_item[15:0];
        else
          d.cmd.index = {cur_item[14:0], 1'b0};
        case (q.func)
          mbsm_pkg::FC_WR_COIL:  d.cmd.wdata = {15'h0000, q.wdata == mbsm_pkg::COIL_ON};
          mbsm_pkg::FC_WR_REG:   d.cmd.wdata = q.wdata;
          mbsm_pkg::FC_WR_COILS: d.cmd.wdata = {15'h0000, item_wdata[0]};
          mbsm_pkg::FC_WR_REGS:  d.cmd.wdata = item_wdata;
          default:               d.cmd.wdata = 16'h0000;
        endcase
        d.item_take = (q.func == mbsm_pkg::FC_WR_COILS) || (q.func == mbsm_pkg::FC_WR_REGS);
        d.st        = mbsm_pkg::S_WAIT;
      end
      mbsm_pkg::S_WAIT:
      begin
        // command holds until the expansion bus acknowledges
        if (iob_ack)
        begin
          d.cmd.valid = 1'b0;
          d.cnt       = q.cnt + 16'h0001;
          d.rsp.func  = q.func;
          d.rsp.code  = mbsm_pkg::EXC_NONE;
          d.rsp.data  = q.cmd.write ? 16'h0000 : iob_rdata;
          d.rsp.valid = !q.cmd.write;
          if (q.cnt + 16'h0001 == q.qty)
          begin
            d.rsp.valid = 1'b1;
            d.rsp.last  = 1'b1;
            d.req_ready = 1'b1;
            d.st        = mbsm_pkg::S_IDLE;
          end
          else
          begin
            d.st = mbsm_pkg::S_ISSUE;
          end
        end
      end
      default:
      begin
        d           = '0;
        d.st        = mbsm_pkg::S_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      q <= '0;
    else
      q <= d;
  end

  assign pt_refuse = q.pt_refuse;
  assign req_ready = q.req_ready;
  assign item_take = q.item_take;
  assign iob_cmd   = q.cmd;
  assign mb_rsp    = q.rsp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_q);

  property p_pt_refuse;
    pt_req |=> (pt_refuse == $past(modbus_mode));
  endproperty
  a_pt_refuse: assert property (p_pt_refuse) else $error("programming access not refused in slave mode");

  property p_no_cfg;
    (q.st == mbsm_pkg::S_IDLE && mb_req.valid && !cfg_loaded) |=> q.st == mbsm_pkg::S_IDLE;
  endproperty
  a_no_cfg: assert property (p_no_cfg) else $error("request served without configuration");

  property p_exc_no_access;
    (q.st == mbsm_pkg::S_CHECK && chk_exc != mbsm_pkg::EXC_NONE) |=>
      (mb_rsp.valid && mb_rsp.last && mb_rsp.code == $past(chk_exc) && !iob_cmd.valid) ##1 !iob_cmd.valid;
  endproperty
  a_exc_no_access: assert property (p_exc_no_access) else $error("bad request not answered by exception");

  property p_reg_limit;
    (q.st == mbsm_pkg::S_CHECK && (q.func == mbsm_pkg::FC_RD_AIN || q.func == mbsm_pkg::FC_WR_REGS) &&
     q.qty > 16'h007d) |=> (mb_rsp.valid && mb_rsp.code == mbsm_pkg::EXC_VALUE);
  endproperty
  a_reg_limit: assert property (p_reg_limit) else $error("register count over 125 accepted");

  property p_coil_write;
    (iob_cmd.valid && iob_cmd.write) |-> (iob_cmd.area == mbsm_pkg::AREA_OUT_IMAGE ||
                                          iob_cmd.area == mbsm_pkg::AREA_VARIABLE);
  endproperty
  a_coil_write: assert property (p_coil_write) else $error("write aimed at a read-only area");

  property p_bit_range;
    (iob_cmd.valid && (iob_cmd.area == mbsm_pkg::AREA_OUT_IMAGE || iob_cmd.area == mbsm_pkg::AREA_DISC_IN))
      |-> iob_cmd.index < 16'h0080;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit index beyond 15.7");

  property p_ain_range;
    (iob_cmd.valid && iob_cmd.area == mbsm_pkg::AREA_ANALOG_IN) |-> (iob_cmd.index < 16'h0040 && !iob_cmd.index[0]);
  endproperty
  a_ain_range: assert property (p_ain_range) else $error("analog word offset out of map");

  property p_cmd_hold;
    (iob_cmd.valid && !iob_ack) |=> (iob_cmd.valid && $stable(iob_cmd.index) && $stable(iob_cmd.wdata));
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("bus command dropped before acknowledge");

  property p_read_echo;
    (iob_cmd.valid && iob_ack && !iob_cmd.write) |=> (mb_rsp.valid && mb_rsp.data == $past(iob_rdata));
  endproperty
  a_read_echo: assert property (p_read_echo) else $error("read data not returned");

  property p_func_ok;
    (mb_rsp.valid && mb_rsp.code == mbsm_pkg::EXC_NONE) |-> (f_exc(mb_rsp.func, 16'h0000, 16'h0001,
                                                             16'h0000) != mbsm_pkg::EXC_FUNCTION);
  endproperty
  a_func_ok: assert property (p_func_ok) else $error("unsupported function answered normally");

  c_read_done:  cover property (mb_rsp.valid && mb_rsp.last && !iob_cmd.write && mb_rsp.code == 8'h00);
  c_multi_wr:   cover property (item_take ##[1:20] item_take);
  c_exception:  cover property (mb_rsp.valid && mb_rsp.code != mbsm_pkg::EXC_NONE);

endmodule : mbsm_top

// ### verification/mbsm_host_model.sv
// host memory responder on the expansion bus side
`timescale 1ns/1ps
module mbsm_host_model (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire mbsm_pkg::mbsm_cmd_t cmd,
  output      logic                ack,
  output      logic [15:0]         rdata
);
  logic [1:0]  wait_q;
  logic [15:0] pat;

  // fixed pattern per place; bit areas carry their bit in bit 0
  assign pat   = (cmd.area < 2'h2) ? {15'h0, cmd.index[0] ^ cmd.index[3]} : ({cmd.area, 14'h0} ^ cmd.index ^ 16'h5a3c);
  // outside the ack cycle the bus shows garbage, never the held value
  assign rdata = ack ? pat : ~pat;

  // one-cycle ack after a random stall of 0 to 3 cycles
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ack    <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (ack)
      ack <= 1'b0;
    else if (cmd.valid && wait_q == 2'h0)
    begin
      ack    <= 1'b1;
      wait_q <= 2'($urandom_range(3));
    end
    else if (cmd.valid)
      wait_q <= wait_q - 2'h1;
endmodule : mbsm_host_model

// ### verification/tb_top.sv
// self-checking bench for the modem slave request interpreter
`timescale 1ns/1ps
module tb_top;
  logic                mclk, rst_n, modbus_mode, cfg_loaded, pt_req, pt_refuse, req_ready, item_take, iob_ack;
  logic [15:0]         item_wdata, iob_rdata;
  mbsm_pkg::mbsm_req_t mb_req;
  mbsm_pkg::mbsm_cmd_t iob_cmd;
  mbsm_pkg::mbsm_rsp_t mb_rsp;
  int                  fail_count, checks_done;
  logic [36:0]         cq[$];
  logic [32:0]         rq[$];
  logic [15:0]         iq[$];

  mbsm_top DUT (.mclk(mclk), .rst_n(rst_n), .modbus_mode(modbus_mode), .cfg_loaded(cfg_loaded), .pt_req(pt_req),
    .pt_refuse(pt_refuse), .mb_req(mb_req), .req_ready(req_ready), .item_wdata(item_wdata), .item_take(item_take),
    .iob_cmd(iob_cmd), .iob_ack(iob_ack), .iob_rdata(iob_rdata), .mb_rsp(mb_rsp));
  mbsm_host_model host (.mclk(mclk), .rst_n(rst_n), .cmd(iob_cmd), .ack(iob_ack), .rdata(iob_rdata));

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // a used-up wait bound counts as a mismatch and ends the run
  task automatic hang(input int k, input int lim);
    if (k >= lim)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : hang

  function automatic logic [15:0] hdata(input logic [1:0] a, input logic [15:0] i);
    return (a < 2'h2) ? {15'h0, i[0] ^ i[3]} : ({a, 14'h0} ^ i ^ 16'h5a3c);
  endfunction : hdata

  // note expectations, hand one request over, wait until it is answered
  task automatic txn(input logic [7:0] fc, input logic [15:0] ad, input logic [15:0] n, input logic [15:0] wd,
                     input logic [7:0] code);
    logic [1:0]  ar;
    logic [15:0] ix, it, nn;
    logic        wr;
    logic        rdy;
    int          k;
    ar = (fc == 8'h01 || fc == 8'h05 || fc == 8'h0f) ? 2'h0 : (fc == 8'h02) ? 2'h1 : (fc == 8'h04) ? 2'h2 : 2'h3;
    wr = fc > 8'h04;
    nn = (fc == 8'h05 || fc == 8'h06) ? 16'h0001 : n;
    for (k = 0; k < nn && code == 8'h00; k++)
    begin
      ix = (ar < 2'h2) ? ad + 16'(k) : (ad + 16'(k)) << 1;
      it = (fc == 8'h05) ? {15'h0, wd == 16'hff00} : (fc == 8'h06) ? wd : 16'($urandom);
      if (fc > 8'h06)
        iq.push_back(it);
      cq.push_back({wr ? ((ar == 2'h0) ? 2'h1 : 2'h0) : 2'h2, wr, ar, ix, it});
      if (!wr)
        rq.push_back({1'b0, k == nn - 1, fc[6:0], 8'h00, hdata(ar, ix)});
    end
    if (code != 8'h00 || wr)
      rq.push_back({1'b0, 1'b1, fc[6:0], code, 16'h0000});
    if (iq.size() > 0)
      item_wdata = iq[0];
    mb_req = '{1'b1, fc, ad, n, wd}; // item numbers arrive zero-based, already mapped to a function
    k = 0;
    // hold the request through the edge at which ready is seen high
    do
    begin
      rdy = req_ready;
      @(posedge mclk);
      k++;
    end
    while (!rdy && k < 100);
    #1 mb_req.valid = 1'b0;
    hang(k, 100);
    k = 0;
    while ((rq.size() > 0 || cq.size() > 0 || !req_ready) && k < 3000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    hang(k, 3000);
  endtask : txn

  // present the next write item once the interpreter consumed one
  always @(posedge mclk)
    if (item_take)
    begin
      void'(iq.pop_front());
      #1 item_wdata = (iq.size() > 0) ? iq[0] : 16'($urandom);
    end

  // compare bus accesses and answers with the oldest note
  always @(posedge mclk)
  begin
    logic [36:0] c;
    logic [32:0] r;
    logic [15:0] m;
    if (iob_cmd.valid && iob_ack)
    begin
      c = '1;
      if (cq.size() > 0)
        c = cq.pop_front();
      m = (c[36:35] == 2'h0) ? 16'hffff : (c[36:35] == 2'h1) ? 16'h0001 : 16'h0000;
      chk({iob_cmd.write, iob_cmd.area, iob_cmd.index, iob_cmd.wdata & m}, {c[34:16], c[15:0] & m});
    end
    if (mb_rsp.valid)
    begin
      r = '1;
      if (rq.size() > 0)
        r = rq.pop_front();
      chk({mb_rsp.last, mb_rsp.func[6:0], mb_rsp.code, r[32] ? r[15:0] : mb_rsp.data}, r[31:0]);
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] a;
    void'($urandom(36));
    rst_n = 1'b0;
    pt_req = 1'b0;
    fail_count = 0;
    checks_done = 0;
    {modbus_mode, cfg_loaded} = 2'h3;
    mb_req = '0;
    item_wdata = 16'h0000;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    txn(8'h01, 16'h007e, 16'h0002, 16'h0000, 8'h00);
    txn(8'h02, 16'h0000, 16'h0003, 16'h0000, 8'h00);
    txn(8'h03, 16'h0001, 16'h0002, 16'h0000, 8'h00);
    txn(8'h04, 16'h001f, 16'h0001, 16'h0000, 8'h00);
    txn(8'h03, 16'h0000, 16'h007d, 16'h0000, 8'h00);
    txn(8'h10, 16'h0000, 16'h007d, 16'h0000, 8'h00);
    txn(8'h10, 16'h0000, 16'h007e, 16'h0000, 8'h03);
    txn(8'h05, 16'h007f, 16'h0001, 16'hff00, 8'h00);
    txn(8'h05, 16'h0000, 16'h0001, 16'h0000, 8'h00);
    txn(8'h06, 16'h0003, 16'h0001, 16'h1234, 8'h00);
    txn(8'h0f, 16'h0008, 16'h0003, 16'h0000, 8'h00);
    txn(8'h10, 16'h0002, 16'h0002, 16'h0000, 8'h00);
    txn(8'h07, 16'h0000, 16'h0001, 16'h0000, 8'h01);
    txn(8'h01, 16'h0080, 16'h0001, 16'h0000, 8'h02);
    txn(8'h04, 16'h001f, 16'h0002, 16'h0000, 8'h02);
    txn(8'h0f, 16'h007f, 16'h0002, 16'h0000, 8'h02);
    txn(8'h03, 16'h0000, 16'h0000, 16'h0000, 8'h03);
    txn(8'h05, 16'h0000, 16'h0001, 16'h1234, 8'h03);
    // random analog reads inside the mapped range
    repeat (6)
    begin
      a = 16'($urandom_range(31));
      txn(8'h04, a, 16'($urandom_range(32 - a, 1)), 16'h0000, 8'h00);
    end
    // without a loaded configuration or without slave mode a request is left untouched
    for (int i = 0; i < 2; i++)
    begin
      {modbus_mode, cfg_loaded} = (i == 0) ? 2'h2 : 2'h1;
      mb_req = '{1'b1, 8'h03, 16'h0000, 16'h0001, 16'h0000};
      repeat (10) @(posedge mclk);
      #1 mb_req.valid = 1'b0;
      chk(req_ready, 1'b1);
    end
    {modbus_mode, cfg_loaded} = 2'h3;
    // programming access is refused only in slave mode
    repeat (2)
    begin
      @(posedge mclk);
      #1 pt_req = 1'b1; // stands for a call framed in 10-bit characters
      @(posedge mclk);
      #1 pt_req = 1'b0;
      chk(pt_refuse, modbus_mode);
      modbus_mode = ~modbus_mode;
    end
    report_and_stop();
  end
endmodule : tb_top
